//--- dv/ethernet_port_pin_mapping_props.sv
// Checker for the port pin mapping, watching port 0 and the uplink.
// Assumes bind onto the top module; link checks wait until config settles.
`timescale 1ns/1ps
module ethernet_port_pin_mapping_props #(
  parameter int NUM_FE = 8
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  input wire logic [NUM_FE-1:0][port_pin_map_pkg::CTRL_W-1:0] port_interface_control_in,
  input wire logic [port_pin_map_pkg::CTRL_W-1:0] uplink_interface_control_in,
  input wire logic [NUM_FE-1:0] fe_clock_source_in,
  input wire logic uplink_clock_source_in,
  input wire port_pin_map_pkg::fe_mode_e [NUM_FE-1:0] port_mode_out,
  input wire port_pin_map_pkg::up_mode_e uplink_mode_out,
  input wire logic module_detect_enabled_out,
  input wire port_pin_map_pkg::fe_mac_tx_s [NUM_FE-1:0] fe_tx_in,
  input wire port_pin_map_pkg::fe_mac_rx_s [NUM_FE-1:0] fe_rx_out,
  input wire port_pin_map_pkg::up_mac_tx_s uplink_tx_in,
  input wire port_pin_map_pkg::fe_pin_in_s [NUM_FE-1:0] fe_pins_in,
  input wire port_pin_map_pkg::fe_pin_out_s [NUM_FE-1:0] fe_pins_out,
  input wire logic [NUM_FE-1:0] fe_tx_clock_pin_oe_out,
  input wire port_pin_map_pkg::up_pin_in_s uplink_pins_in,
  input wire port_pin_map_pkg::up_pin_out_s uplink_pins_out,
  input wire port_pin_map_pkg::up_mac_rx_s uplink_rx_out,
  input wire logic uplink_rx_clock_pin_oe_out
);
  logic [1:0] fc;
  logic [1:0] uc;
  logic [3:0] fm;
  logic [7:0] um;
  logic fck;
  logic ok;
  logic [6:0] watch;
  logic [6:0] prev;
  logic [5:0] calm;
  assign fc = port_interface_control_in[0][4:3];
  assign uc = uplink_interface_control_in[4:3];
  assign fm = (port_mode_out[0] == port_pin_map_pkg::FE_RMII) ? 4'h3 :
              (port_mode_out[0] == port_pin_map_pkg::FE_MII) ? 4'hf :
              (port_mode_out[0] == port_pin_map_pkg::FE_GPSI) ? 4'h1 : 4'h0;
  assign um = (uplink_mode_out == port_pin_map_pkg::UP_GMII) ? 8'hff :
              (uplink_mode_out == port_pin_map_pkg::UP_MII) ? 8'h0f : 8'h00;
  assign fck = (fm == 4'hf) || (fm == 4'h1);
  assign watch = {port_mode_out[0], uplink_mode_out, fe_clock_source_in[0], uplink_clock_source_in,
                  module_detect_enabled_out};
  assign ok = (calm >= 6'h28) && (prev == watch);
  // Link cycles since the config last moved
  always_ff @(posedge link_clk_in) begin
    prev <= watch;
    if (srst_in || (prev != watch)) calm <= 6'h00;
    else if (calm != 6'h3f) calm <= calm + 6'h01;
  end
  a_fe_decode: assert property (@(posedge clk_in) disable iff (srst_in)
    !$past(srst_in) && !$past(srst_in, 2) && !module_detect_enabled_out |-> port_mode_out[0] ==
    ($past(fc) == port_pin_map_pkg::FE_CODE_RMII ? port_pin_map_pkg::FE_RMII :
     $past(fc) == port_pin_map_pkg::FE_CODE_MII ? port_pin_map_pkg::FE_MII :
     $past(fc) == port_pin_map_pkg::FE_CODE_GPSI ? port_pin_map_pkg::FE_GPSI : port_pin_map_pkg::FE_NONE))
    else $error("access port mode decode wrong");
  a_up_decode: assert property (@(posedge clk_in) disable iff (srst_in)
    !$past(srst_in) && !$past(srst_in, 2) && !module_detect_enabled_out |-> uplink_mode_out ==
    ($past(uc) == port_pin_map_pkg::UP_CODE_GMII ? port_pin_map_pkg::UP_GMII :
     $past(uc) == port_pin_map_pkg::UP_CODE_MII ? port_pin_map_pkg::UP_MII : port_pin_map_pkg::UP_NONE))
    else $error("uplink mode decode wrong");
  a_fe_tx_pins: assert property (@(posedge link_clk_in) disable iff (srst_in) ok |->
    fe_pins_out[0] == {$past(fe_tx_in[0].tx_enable) & |fm, $past(fe_tx_in[0].txd) & fm})
    else $error("access transmit pins wrong");
  a_fe_rx_data: assert property (@(posedge link_clk_in) disable iff (srst_in) ok |->
    fe_rx_out[0].rxd == ($past(fe_pins_in[0].rxd, 3) & fm)) else $error("access receive data wrong");
  a_fe_carrier: assert property (@(posedge link_clk_in) disable iff (srst_in) ok |->
    fe_rx_out[0].rx_valid == (fm[1] & $past(fe_pins_in[0].carrier_valid_pin, 3)) &&
    fe_rx_out[0].carrier == (fm[0] & ~fm[3] & $past(fe_pins_in[0].carrier_valid_pin, 3)))
    else $error("access carrier meaning wrong");
  a_fe_clock_oe: assert property (@(posedge link_clk_in) disable iff (srst_in) ok |->
    fe_tx_clock_pin_oe_out[0] == (fck && fe_clock_source_in[0])) else $error("access clock enable wrong");
  a_up_tx_pins: assert property (@(posedge link_clk_in) disable iff (srst_in) ok |->
    uplink_pins_out.txd == ($past(uplink_tx_in.txd) & um) &&
    uplink_pins_out.tx_enable == ($past(uplink_tx_in.tx_enable) & |um)) else $error("uplink transmit wrong");
  a_gig_clock: assert property (@(posedge link_clk_in) disable iff (srst_in) ok |->
    (um == 8'hff) ? $changed(uplink_pins_out.gig_tx_clock_pin) : !uplink_pins_out.gig_tx_clock_pin)
    else $error("gigabit transmit clock wrong");
  a_up_rx_error: assert property (@(posedge link_clk_in) disable iff (srst_in) ok |->
    uplink_rx_out.rx_error == (um[7] & $past(uplink_pins_in.rx_error_pin, 3)))
    else $error("uplink receive error wrong");
  a_up_rxclk_oe: assert property (@(posedge link_clk_in) disable iff (srst_in) ok |->
    uplink_rx_clock_pin_oe_out == ((um == 8'h0f) && uplink_clock_source_in)) else $error("uplink clock enable wrong");
endmodule // ethernet_port_pin_mapping_props

bind ethernet_port_pin_mapping ethernet_port_pin_mapping_props #(.NUM_FE(NUM_FE)) u_props (.clk_in, .srst_in,
  .link_clk_in, .port_interface_control_in, .uplink_interface_control_in, .fe_clock_source_in,
  .uplink_clock_source_in, .port_mode_out, .uplink_mode_out, .module_detect_enabled_out, .fe_tx_in, .fe_rx_out,
  .uplink_tx_in, .fe_pins_in, .fe_pins_out, .fe_tx_clock_pin_oe_out, .uplink_pins_in, .uplink_pins_out,
  .uplink_rx_out, .uplink_rx_clock_pin_oe_out);

//--- dv/phy_partner.sv
// PHY side model: drives every receive pin with a changing pattern, except clock pins whose output enable is set, which carry the DUT clock back.
// Assumes hold_in freezes the pattern so the bench can compare settled pins.
`timescale 1ns/1ps
module phy_partner (
  input wire logic link_clk_in,
  input wire logic hold_in,
  input wire logic [7:0] tx_clk_in,
  input wire logic [7:0] tx_oe_in,
  input wire logic [7:0] rx_clk_in,
  input wire logic [7:0] rx_oe_in,
  input wire logic up_clk_in,
  input wire logic up_oe_in,
  output port_pin_map_pkg::fe_pin_in_s [7:0] fe_out,
  output port_pin_map_pkg::up_pin_in_s up_out
);
  logic [15:0] lfsr = 16'hace1;
  always @(negedge link_clk_in) begin
    if (!hold_in) lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      fe_out[i] = {lfsr[i+:6], tx_oe_in[i] ? tx_clk_in[i] : lfsr[i+6], rx_oe_in[i] ? rx_clk_in[i] : lfsr[i+7]};
    end
    up_out = {lfsr[15:8] ^ lfsr[7:0], lfsr[4:1], up_oe_in ? up_clk_in : lfsr[9], lfsr[11:10]};
  end
endmodule // phy_partner

//--- dv/test_ethernet_port_pin_mapping.sv
// Bench for the port pin mapping: control, MAC and PHY sides driven.
// Assumes the PHY partner model and the bound checker.
`timescale 1ns/1ps
module test_ethernet_port_pin_mapping;
  logic clk_in = 1'h0;
  logic link_clk = 1'h0;
  logic srst_in = 1'h1;
  logic strap = 1'h0;
  logic usrc = 1'h0;
  logic hold = 1'h0;
  logic [7:0] fsrc = 8'h00;
  logic [8:0] pres = 9'h000;
  logic [7:0][4:0] fctl = '0;
  logic [4:0] uctl = 5'h00;
  port_pin_map_pkg::fe_mac_tx_s [7:0] ftx = '0;
  port_pin_map_pkg::up_mac_tx_s utx = '0;
  port_pin_map_pkg::fe_mode_e [7:0] fmode;
  port_pin_map_pkg::up_mode_e umode;
  port_pin_map_pkg::fe_mac_rx_s [7:0] frx;
  port_pin_map_pkg::up_mac_rx_s urx;
  port_pin_map_pkg::fe_pin_in_s [7:0] fpi;
  port_pin_map_pkg::fe_pin_out_s [7:0] fpo;
  port_pin_map_pkg::up_pin_in_s upi;
  port_pin_map_pkg::up_pin_out_s upo;
  logic [7:0] tco, tcoe, rco, rcoe;
  logic uco, ucoe, det;
  int bad_count = 0;
  int checks = 0;

  always #5 clk_in = ~clk_in;
  initial begin
    #0.7;
    forever #3 link_clk = ~link_clk;
  end

  ethernet_port_pin_mapping u_dut (.clk_in(clk_in), .srst_in(srst_in), .link_clk_in(link_clk),
    .port_interface_control_in(fctl), .uplink_interface_control_in(uctl), .fe_clock_source_in(fsrc),
    .uplink_clock_source_in(usrc), .module_detect_strap_in(strap), .module_present_in(pres),
    .port_mode_out(fmode), .uplink_mode_out(umode), .module_detect_enabled_out(det), .fe_tx_in(ftx),
    .fe_rx_out(frx), .uplink_tx_in(utx), .uplink_rx_out(urx), .fe_pins_in(fpi), .fe_pins_out(fpo),
    .fe_tx_clock_pin_out(tco), .fe_tx_clock_pin_oe_out(tcoe), .fe_rx_clock_pin_out(rco),
    .fe_rx_clock_pin_oe_out(rcoe), .uplink_pins_in(upi), .uplink_pins_out(upo),
    .uplink_rx_clock_pin_out(uco), .uplink_rx_clock_pin_oe_out(ucoe));
  phy_partner u_phy (.link_clk_in(link_clk), .hold_in(hold), .tx_clk_in(tco), .tx_oe_in(tcoe), .rx_clk_in(rco),
    .rx_oe_in(rcoe), .up_clk_in(uco), .up_oe_in(ucoe), .fe_out(fpi), .up_out(upi));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wl(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  // Freeze the PHY pattern long enough to compare settled receive data
  task automatic freeze();
    wc(1);
    hold = 1'h1;
    wl(6);
  endtask
  function automatic port_pin_map_pkg::fe_mac_rx_s fexp(input logic [3:0] m, input port_pin_map_pkg::fe_pin_in_s p);
    logic ck;
    ck = (m == 4'hf) || (m == 4'h1);
    fexp = {p.rxd & m, m[1] & p.carrier_valid_pin, m[0] & ~m[3] & p.carrier_valid_pin, ck & p.col,
            ck & p.tx_clock_pin, ck & p.rx_clock_pin};
  endfunction
  function automatic port_pin_map_pkg::up_mac_rx_s uexp(input logic [7:0] m, input port_pin_map_pkg::up_pin_in_s p);
    logic u;
    u = |m;
    uexp = {p.rxd & m, u & p.rxdv, m[7] & p.rx_error_pin, u & p.crs, u & p.col, u & p.rx_clock_pin,
            u & p.reference_clock_pin, u & p.mii_tx_clock_pin};
  endfunction

  task automatic fe_modes();
    logic [1:0] code [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
    logic [3:0] mask [4] = '{4'h3, 4'hf, 4'h1, 4'h0};
    port_pin_map_pkg::fe_mode_e em [4] = '{port_pin_map_pkg::FE_RMII, port_pin_map_pkg::FE_MII,
                                           port_pin_map_pkg::FE_GPSI, port_pin_map_pkg::FE_NONE};
    logic [15:0] tc;
    for (int k = 0; k < 4; k++) begin
      wc(1);
      for (int i = 0; i < 8; i++) begin
        fctl[i] = {code[k], 3'h5};
        ftx[i] = {1'h1, 4'ha ^ 4'(i)};
      end
      fsrc = 8'hff;
      wc(3);
      for (int i = 0; i < 8; i++) check("fe mode", fmode[i], em[k]);
      wl(40);
      for (int i = 0; i < 8; i++) begin
        check("fe tx pins", fpo[i], {|mask[k], ftx[i].txd & mask[k]});
        check("fe clock oe", {tcoe[i], rcoe[i]}, {2{mask[k] == 4'hf || mask[k] == 4'h1}});
      end
      tc = {tco, rco};
      wl(1);
      check("fe clocks", tc ^ {tco, rco}, {16{mask[k] == 4'hf || mask[k] == 4'h1}});
      wc(1);
      fsrc = 8'h00;
      wl(40);
      freeze();
      for (int i = 0; i < 8; i++) check("fe rx", frx[i], fexp(mask[k], fpi[i]));
      wc(1);
      hold = 1'h0;
    end
  endtask

  task automatic up_modes();
    logic [1:0] code [3] = '{2'h3, 2'h0, 2'h1};
    logic [7:0] mask [3] = '{8'hff, 8'h0f, 8'h00};
    port_pin_map_pkg::up_mode_e em [3] = '{port_pin_map_pkg::UP_GMII, port_pin_map_pkg::UP_MII,
                                           port_pin_map_pkg::UP_NONE};
    logic g, c;
    for (int k = 0; k < 3; k++) begin
      wc(1);
      uctl = {code[k], 3'h2};
      utx = {1'h1, 1'h1, 8'h5a};
      usrc = 1'h1;
      wc(3);
      check("up mode", umode, em[k]);
      wl(40);
      check("up tx", upo[10:1], {utx.txd & mask[k], |mask[k], |mask[k]});
      check("up rx clock oe", ucoe, mask[k] == 8'h0f);
      g = upo.gig_tx_clock_pin;
      c = uco;
      wl(1);
      check("up rx clock", c ^ uco, mask[k] == 8'h0f);
      check("gig clock", {g ^ upo.gig_tx_clock_pin, upo.gig_tx_clock_pin & ~mask[k][7]}, {mask[k][7], 1'h0});
      wc(1);
      usrc = 1'h0;
      wl(40);
      freeze();
      check("up rx", urx, uexp(mask[k], upi));
      wc(1);
      hold = 1'h0;
    end
  endtask

  task automatic detect();
    wc(1);
    srst_in = 1'h1;
    strap = 1'h1;
    pres = 9'h001;
    uctl = {port_pin_map_pkg::UP_CODE_GMII, 3'h0};
    for (int i = 0; i < 8; i++) begin
      fctl[i] = {port_pin_map_pkg::FE_CODE_RMII, 3'h0};
      ftx[i] = {1'h1, 4'hf};
    end
    wc(6);
    check("reset state", {fmode[0], det}, 3'h0);
    srst_in = 1'h0;
    wc(6);
    check("detect on", det, 1'h1);
    check("present port", fmode[0], port_pin_map_pkg::FE_RMII);
    check("absent port", fmode[1], port_pin_map_pkg::FE_NONE);
    check("absent uplink", umode, port_pin_map_pkg::UP_NONE);
    wl(40);
    check("absent tx enable", fpo[1], 5'h00);
    check("present tx", fpo[0], 5'h13);
    wc(1);
    pres = 9'h1ff;
    wc(6);
    check("uplink present", umode, port_pin_map_pkg::UP_GMII);
  endtask

  initial begin
    wc(6);
    srst_in = 1'h0;
    wl(20);
    fe_modes();
    up_modes();
    detect();
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    close_out();
  end
endmodule // test_ethernet_port_pin_mapping

//--- rtl/cfg_word_sync.sv
// Handshake crossing that carries a configuration word between two clocks.
// Assumes the source word changes rarely; each change is sent once, whole.
`timescale 1ns/1ps
module cfg_word_sync #(
  parameter int W = 8
) (
  input wire logic src_clk_in,
  input wire logic src_srst_in,
  input wire logic [W-1:0] src_data_in,
  input wire logic dst_clk_in,
  input wire logic dst_srst_in,
  output logic [W-1:0] dst_data_out,
  output logic dst_valid_out
);

  typedef struct packed {
    logic [W-1:0] held;
    logic req;
    logic busy;
    logic primed;
    logic [port_pin_map_pkg::SYNC_STAGES-1:0] ack_pipe;
  } src_state_s;

  typedef struct packed {
    logic [W-1:0] data;
    logic valid;
    logic ack;
    logic [port_pin_map_pkg::SYNC_STAGES-1:0] req_pipe;
  } dst_state_s;

  src_state_s sq;
  src_state_s next_sq;
  dst_state_s dq;
  dst_state_s next_dq;

  always_comb begin
    next_sq = sq;
    next_sq.ack_pipe = {sq.ack_pipe[0], dq.ack};
    if (sq.busy && (sq.ack_pipe[1] == sq.req)) begin
      next_sq.busy = 1'b0;
    end
    // Launch only while idle, so the held word stays stable in flight
    if (!sq.busy && (!sq.primed || (src_data_in != sq.held))) begin
      next_sq.held = src_data_in;
      next_sq.req = ~sq.req;
      next_sq.busy = 1'b1;
      next_sq.primed = 1'b1;
    end
    if (src_srst_in) begin
      next_sq = '0;
    end
  end

  always_ff @(posedge src_clk_in) begin
    sq <= next_sq;
  end

  always_comb begin
    next_dq = dq;
    next_dq.req_pipe = {dq.req_pipe[0], sq.req};
    if (dq.req_pipe[1] != dq.ack) begin
      next_dq.data = sq.held;
      next_dq.valid = 1'b1;
      next_dq.ack = dq.req_pipe[1];
    end
    if (dst_srst_in) begin
      next_dq = '0;
    end
  end

  always_ff @(posedge dst_clk_in) begin
    dq <= next_dq;
  end

  assign dst_data_out = dq.data;
  assign dst_valid_out = dq.valid;

endmodule // cfg_word_sync

//--- rtl/ethernet_port_pin_mapping.sv
// Pin function mapping for eight fast access ports and one uplink port.
// Control side runs on clk_in; pin-facing logic runs on the link clock.
// Assumes the MAC-side ports are synchronous to link_clk_in.
`timescale 1ns/1ps

module ethernet_port_pin_mapping #(
  parameter int NUM_FE = port_pin_map_pkg::NUM_FE
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  input wire logic [NUM_FE-1:0][port_pin_map_pkg::CTRL_W-1:0] port_interface_control_in,
  input wire logic [port_pin_map_pkg::CTRL_W-1:0] uplink_interface_control_in,
  input wire logic [NUM_FE-1:0] fe_clock_source_in,
  input wire logic uplink_clock_source_in,
  input wire logic module_detect_strap_in,
  input wire logic [NUM_FE:0] module_present_in,
  output port_pin_map_pkg::fe_mode_e [NUM_FE-1:0] port_mode_out,
  output port_pin_map_pkg::up_mode_e uplink_mode_out,
  output logic module_detect_enabled_out,
  input wire port_pin_map_pkg::fe_mac_tx_s [NUM_FE-1:0] fe_tx_in,
  output port_pin_map_pkg::fe_mac_rx_s [NUM_FE-1:0] fe_rx_out,
  input wire port_pin_map_pkg::up_mac_tx_s uplink_tx_in,
  output port_pin_map_pkg::up_mac_rx_s uplink_rx_out,
  input wire port_pin_map_pkg::fe_pin_in_s [NUM_FE-1:0] fe_pins_in,
  output port_pin_map_pkg::fe_pin_out_s [NUM_FE-1:0] fe_pins_out,
  output logic [NUM_FE-1:0] fe_tx_clock_pin_out,
  output logic [NUM_FE-1:0] fe_tx_clock_pin_oe_out,
  output logic [NUM_FE-1:0] fe_rx_clock_pin_out,
  output logic [NUM_FE-1:0] fe_rx_clock_pin_oe_out,
  input wire port_pin_map_pkg::up_pin_in_s uplink_pins_in,
  output port_pin_map_pkg::up_pin_out_s uplink_pins_out,
  output logic uplink_rx_clock_pin_out,
  output logic uplink_rx_clock_pin_oe_out
);

  localparam int CFG_W = $bits(port_pin_map_pkg::cfg_s);

  typedef struct packed {
    logic [port_pin_map_pkg::SYNC_STAGES-1:0] strap_pipe;
    logic [NUM_FE:0] present_s1;
    logic [NUM_FE:0] present_s2;
    logic strap_caught;
    logic detect_en;
    port_pin_map_pkg::cfg_s cfg;
  } ctl_state_s;

  typedef struct packed {
    logic [port_pin_map_pkg::SYNC_STAGES-1:0] rst_pipe;
    logic div_toggle;
    port_pin_map_pkg::fe_pin_in_s [NUM_FE-1:0] fe_s1;
    port_pin_map_pkg::fe_pin_in_s [NUM_FE-1:0] fe_s2;
    port_pin_map_pkg::up_pin_in_s up_s1;
    port_pin_map_pkg::up_pin_in_s up_s2;
    port_pin_map_pkg::fe_pin_out_s [NUM_FE-1:0] fe_pins;
    logic [NUM_FE-1:0] fe_txclk;
    logic [NUM_FE-1:0] fe_txclk_oe;
    logic [NUM_FE-1:0] fe_rxclk;
    logic [NUM_FE-1:0] fe_rxclk_oe;
    port_pin_map_pkg::fe_mac_rx_s [NUM_FE-1:0] fe_rx;
    port_pin_map_pkg::up_pin_out_s up_pins;
    logic up_rxclk;
    logic up_rxclk_oe;
    port_pin_map_pkg::up_mac_rx_s up_rx;
  } link_state_s;

  ctl_state_s cq;
  ctl_state_s next_cq;
  link_state_s lq;
  link_state_s next_lq;
  port_pin_map_pkg::cfg_s link_cfg;
  logic [CFG_W-1:0] link_cfg_bits;
  logic link_cfg_valid;
  logic link_rst;

  assign link_rst = lq.rst_pipe[port_pin_map_pkg::SYNC_STAGES-1];

  // Control domain: strap, presence and mode decode
  always_comb begin
    logic [port_pin_map_pkg::MODE_W-1:0] code;
    logic present;
    code = '0;
    present = 1'b0;
    next_cq = cq;
    next_cq.strap_pipe = {cq.strap_pipe[0], module_detect_strap_in};
    next_cq.present_s1 = module_present_in;
    next_cq.present_s2 = cq.present_s1;
    // strap caught once after reset release
    if (!cq.strap_caught) begin
      next_cq.strap_caught = 1'b1;
      next_cq.detect_en = cq.strap_pipe[1];
    end
    // one decoder for every access port
    for (int i = 0; i < NUM_FE; i++) begin
      code = port_interface_control_in[i][port_pin_map_pkg::MODE_LSB +: port_pin_map_pkg::MODE_W];
      present = !cq.detect_en || cq.present_s2[i];
      if (!cq.strap_caught || !present) begin
        next_cq.cfg.fe_mode[i] = port_pin_map_pkg::FE_NONE;
      end else if (code == port_pin_map_pkg::FE_CODE_RMII) begin
        next_cq.cfg.fe_mode[i] = port_pin_map_pkg::FE_RMII;
      end else if (code == port_pin_map_pkg::FE_CODE_MII) begin
        next_cq.cfg.fe_mode[i] = port_pin_map_pkg::FE_MII;
      end else if (code == port_pin_map_pkg::FE_CODE_GPSI) begin
        next_cq.cfg.fe_mode[i] = port_pin_map_pkg::FE_GPSI;
      end else begin
        next_cq.cfg.fe_mode[i] = port_pin_map_pkg::FE_NONE;
      end
    end
    next_cq.cfg.fe_clk_src = fe_clock_source_in;
    next_cq.cfg.up_clk_src = uplink_clock_source_in;
    code = uplink_interface_control_in[port_pin_map_pkg::MODE_LSB +: port_pin_map_pkg::MODE_W];
    present = !cq.detect_en || cq.present_s2[NUM_FE];
    // uplink code decode, absent kept apart
    if (!cq.strap_caught || !present) begin
      next_cq.cfg.up_mode = port_pin_map_pkg::UP_NONE;
    end else if (code == port_pin_map_pkg::UP_CODE_GMII) begin
      next_cq.cfg.up_mode = port_pin_map_pkg::UP_GMII;
    end else if (code == port_pin_map_pkg::UP_CODE_MII) begin
      next_cq.cfg.up_mode = port_pin_map_pkg::UP_MII;
    end else begin
      next_cq.cfg.up_mode = port_pin_map_pkg::UP_NONE;
    end
    if (srst_in) begin
      next_cq.strap_caught = 1'b0;
      next_cq.detect_en = 1'b0;
      next_cq.cfg = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    cq <= next_cq;
  end

  cfg_word_sync #(
    .W(CFG_W)
  ) u_cfg_sync (
    .src_clk_in(clk_in),
    .src_srst_in(srst_in),
    .src_data_in(cq.cfg),
    .dst_clk_in(link_clk_in),
    .dst_srst_in(link_rst),
    .dst_data_out(link_cfg_bits),
    .dst_valid_out(link_cfg_valid)
  );

  assign link_cfg = link_cfg_valid ? port_pin_map_pkg::cfg_s'(link_cfg_bits) : '0;

  // Link domain: pin direction and data steering
  always_comb begin
    port_pin_map_pkg::fe_pin_in_s fp;
    port_pin_map_pkg::up_pin_in_s up;
    logic src;
    fp = '0;
    up = '0;
    src = 1'b0;
    next_lq = lq;
    next_lq.rst_pipe = {lq.rst_pipe[0], srst_in};
    next_lq.div_toggle = ~lq.div_toggle;
    next_lq.fe_s1 = fe_pins_in;
    next_lq.fe_s2 = lq.fe_s1;
    next_lq.up_s1 = uplink_pins_in;
    next_lq.up_s2 = lq.up_s1;
    // unused outputs low, unused inputs zero
    next_lq.fe_pins = '0;
    next_lq.fe_rx = '0;
    next_lq.fe_txclk = '0;
    next_lq.fe_txclk_oe = '0;
    next_lq.fe_rxclk = '0;
    next_lq.fe_rxclk_oe = '0;
    next_lq.up_pins = '0;
    next_lq.up_rx = '0;
    next_lq.up_rxclk = 1'b0;
    next_lq.up_rxclk_oe = 1'b0;
    for (int i = 0; i < NUM_FE; i++) begin
      fp = lq.fe_s2[i];
      src = link_cfg.fe_clk_src[i];
      unique case (link_cfg.fe_mode[i])
        port_pin_map_pkg::FE_NONE: begin
          // enable driven low with no module
          next_lq.fe_pins[i].tx_enable_pin = 1'b0;
        end
        port_pin_map_pkg::FE_RMII: begin
          next_lq.fe_pins[i].tx_enable_pin = fe_tx_in[i].tx_enable;
          next_lq.fe_pins[i].txd[port_pin_map_pkg::RMII_DATA_W-1:0] =
            fe_tx_in[i].txd[port_pin_map_pkg::RMII_DATA_W-1:0];
          next_lq.fe_rx[i].rxd[port_pin_map_pkg::RMII_DATA_W-1:0] =
            fp.rxd[port_pin_map_pkg::RMII_DATA_W-1:0];
          next_lq.fe_rx[i].rx_valid = fp.carrier_valid_pin;
          next_lq.fe_rx[i].carrier = fp.carrier_valid_pin;
        end
        port_pin_map_pkg::FE_MII: begin
          next_lq.fe_pins[i].tx_enable_pin = fe_tx_in[i].tx_enable;
          next_lq.fe_pins[i].txd = fe_tx_in[i].txd;
          next_lq.fe_rx[i].rxd = fp.rxd;
          next_lq.fe_rx[i].collision = fp.col;
          next_lq.fe_rx[i].rx_valid = fp.carrier_valid_pin;
        end
        port_pin_map_pkg::FE_GPSI: begin
          next_lq.fe_pins[i].tx_enable_pin = fe_tx_in[i].tx_enable;
          next_lq.fe_pins[i].txd[0] = fe_tx_in[i].txd[0];
          next_lq.fe_rx[i].rxd[0] = fp.rxd[0];
          next_lq.fe_rx[i].collision = fp.col;
          next_lq.fe_rx[i].carrier = fp.carrier_valid_pin;
        end
      endcase
      if ((link_cfg.fe_mode[i] == port_pin_map_pkg::FE_MII) ||
          (link_cfg.fe_mode[i] == port_pin_map_pkg::FE_GPSI)) begin
        next_lq.fe_txclk_oe[i] = src;
        next_lq.fe_rxclk_oe[i] = src;
        next_lq.fe_txclk[i] = src & lq.div_toggle;
        next_lq.fe_rxclk[i] = src & lq.div_toggle;
        next_lq.fe_rx[i].tx_clock_level = ~src & fp.tx_clock_pin;
        next_lq.fe_rx[i].rx_clock_level = ~src & fp.rx_clock_pin;
      end
    end
    up = lq.up_s2;
    src = link_cfg.up_clk_src;
    unique case (link_cfg.up_mode)
      port_pin_map_pkg::UP_NONE: begin
        next_lq.up_pins = '0;
      end
      port_pin_map_pkg::UP_GMII: begin
        next_lq.up_pins.txd = uplink_tx_in.txd;
        next_lq.up_rx.rxd = up.rxd;
        // gigabit clock driven in GMII only
        next_lq.up_pins.gig_tx_clock_pin = lq.div_toggle;
        next_lq.up_rx.rx_error = up.rx_error_pin;
        next_lq.up_rx.rx_clock_level = up.rx_clock_pin;
      end
      port_pin_map_pkg::UP_MII: begin
        next_lq.up_pins.txd[port_pin_map_pkg::MII_DATA_W-1:0] =
          uplink_tx_in.txd[port_pin_map_pkg::MII_DATA_W-1:0];
        next_lq.up_rx.rxd[port_pin_map_pkg::MII_DATA_W-1:0] =
          up.rxd[port_pin_map_pkg::MII_DATA_W-1:0];
        next_lq.up_rxclk_oe = src;
        next_lq.up_rxclk = src & lq.div_toggle;
        next_lq.up_rx.rx_clock_level = ~src & up.rx_clock_pin;
      end
      default: begin
        next_lq.up_pins = '0;
      end
    endcase
    if (link_cfg.up_mode != port_pin_map_pkg::UP_NONE) begin
      next_lq.up_pins.tx_enable = uplink_tx_in.tx_enable;
      next_lq.up_pins.tx_error = uplink_tx_in.tx_error;
      next_lq.up_rx.rx_valid = up.rxdv;
      next_lq.up_rx.carrier = up.crs;
      next_lq.up_rx.collision = up.col;
      next_lq.up_rx.reference_clock_level = up.reference_clock_pin;
      // MII transmit clock input in both
      next_lq.up_rx.mii_tx_clock_level = up.mii_tx_clock_pin;
    end
    if (link_rst) begin
      next_lq = '0;
      next_lq.rst_pipe = {lq.rst_pipe[0], srst_in};
      next_lq.fe_s1 = fe_pins_in;
      next_lq.fe_s2 = lq.fe_s1;
      next_lq.up_s1 = uplink_pins_in;
      next_lq.up_s2 = lq.up_s1;
    end
  end

  always_ff @(posedge link_clk_in) begin
    lq <= next_lq;
  end

  assign port_mode_out = cq.cfg.fe_mode;
  assign uplink_mode_out = cq.cfg.up_mode;
  assign module_detect_enabled_out = cq.detect_en;
  assign fe_rx_out = lq.fe_rx;
  assign uplink_rx_out = lq.up_rx;
  assign fe_pins_out = lq.fe_pins;
  assign fe_tx_clock_pin_out = lq.fe_txclk;
  assign fe_tx_clock_pin_oe_out = lq.fe_txclk_oe;
  assign fe_rx_clock_pin_out = lq.fe_rxclk;
  assign fe_rx_clock_pin_oe_out = lq.fe_rxclk_oe;
  assign uplink_pins_out = lq.up_pins;
  assign uplink_rx_clock_pin_out = lq.up_rxclk;
  assign uplink_rx_clock_pin_oe_out = lq.up_rxclk_oe;

endmodule // ethernet_port_pin_mapping

//--- rtl/port_pin_map_pkg.sv
// Constants, modes and carrier structs for the Ethernet port pin mapping.
// Assumes a single switch with eight fast access ports and one uplink.
package port_pin_map_pkg;

  localparam int NUM_FE = 8;
  localparam int FE_DATA_W = 4;
  localparam int UP_DATA_W = 8;
  localparam int CTRL_W = 5;
  localparam int MODE_LSB = 3;
  localparam int MODE_W = 2;
  localparam int RMII_DATA_W = 2;
  localparam int MII_DATA_W = 4;
  localparam int SYNC_STAGES = 2;

  localparam logic [MODE_W-1:0] FE_CODE_RMII = 2'h3;
  localparam logic [MODE_W-1:0] FE_CODE_MII = 2'h1;
  localparam logic [MODE_W-1:0] FE_CODE_GPSI = 2'h0;
  localparam logic [MODE_W-1:0] UP_CODE_GMII = 2'h3;
  localparam logic [MODE_W-1:0] UP_CODE_MII = 2'h0;

  // Zero value is the inactive state, so a reset port drives nothing
  typedef enum logic [1:0] {
    FE_NONE,
    FE_RMII,
    FE_MII,
    FE_GPSI
  } fe_mode_e;

  typedef enum logic [1:0] {
    UP_NONE,
    UP_GMII,
    UP_MII
  } up_mode_e;

  typedef struct packed {
    fe_mode_e [NUM_FE-1:0] fe_mode;
    logic [NUM_FE-1:0] fe_clk_src;
    up_mode_e up_mode;
    logic up_clk_src;
  } cfg_s;

  typedef struct packed {
    logic [FE_DATA_W-1:0] rxd;
    logic carrier_valid_pin;
    logic col;
    logic tx_clock_pin;
    logic rx_clock_pin;
  } fe_pin_in_s;

  typedef struct packed {
    logic tx_enable_pin;
    logic [FE_DATA_W-1:0] txd;
  } fe_pin_out_s;

  typedef struct packed {
    logic tx_enable;
    logic [FE_DATA_W-1:0] txd;
  } fe_mac_tx_s;

  typedef struct packed {
    logic [FE_DATA_W-1:0] rxd;
    logic rx_valid;
    logic carrier;
    logic collision;
    logic tx_clock_level;
    logic rx_clock_level;
  } fe_mac_rx_s;

  typedef struct packed {
    logic [UP_DATA_W-1:0] rxd;
    logic rxdv;
    logic rx_error_pin;
    logic crs;
    logic col;
    logic rx_clock_pin;
    logic reference_clock_pin;
    logic mii_tx_clock_pin;
  } up_pin_in_s;

  typedef struct packed {
    logic [UP_DATA_W-1:0] txd;
    logic tx_enable;
    logic tx_error;
    logic gig_tx_clock_pin;
  } up_pin_out_s;

  typedef struct packed {
    logic tx_enable;
    logic tx_error;
    logic [UP_DATA_W-1:0] txd;
  } up_mac_tx_s;

  typedef struct packed {
    logic [UP_DATA_W-1:0] rxd;
    logic rx_valid;
    logic rx_error;
    logic carrier;
    logic collision;
    logic rx_clock_level;
    logic reference_clock_level;
    logic mii_tx_clock_level;
  } up_mac_rx_s;

endpackage
